//--- design/diagnostic_error_capture_bank.sv
// diagnostic error capture bank with avalon-mm slave and interrupt
//
// Contract
// - detected error code goes into code word
// - code word equals newest error history entry
// - timestamp word one: BCD year, month
// - timestamp word two: BCD day, hour
// - timestamp word three: BCD minute, second
// - category code names common, individual formats
// - common words describe latched error per category
// - slot reads FF when nothing mounted
// - io word FFFF when unknown or branch
// - io word holds start number over sixteen
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none
module diagnostic_error_capture_bank (
	input  wire logic              clock,
	input  wire logic              srst,
	// error report from self-diagnostics
	input  wire logic              errValid,
	input  wire logic [15:0]       errCode,
	input  wire logic [7:0]        commonCat,
	input  wire logic [7:0]        indivCat,
	input  wire logic              slotMounted,
	input  wire logic [7:0]        slotNo,
	input  wire logic [15:0]       ioStart,
	input  wire logic              ioUnknown,
	input  wire logic              branchModule,
	input  wire logic [10:0][15:0] rawCommon,
	// calendar clock, BCD
	input  wire logic [7:0]        rtcYear,
	input  wire logic [7:0]        rtcMonth,
	input  wire logic [7:0]        rtcDay,
	input  wire logic [7:0]        rtcHour,
	input  wire logic [7:0]        rtcMinute,
	input  wire logic [7:0]        rtcSecond,
	// avalon-mm slave
	input  wire logic [6:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	// interrupt
	output logic                   irq
);
	err_record_if rec ();

	// formatting of code, category and common words
	error_detail_format uFormat (
		.errValid     (errValid),
		.errCode      (errCode),
		.commonCat    (commonCat),
		.indivCat     (indivCat),
		.slotMounted  (slotMounted),
		.slotNo       (slotNo),
		.ioStart      (ioStart),
		.ioUnknown    (ioUnknown),
		.branchModule (branchModule),
		.rawCommon    (rawCommon),
		.rec          (rec.fmt)
	);

	// timestamp packing from the calendar clock
	time_stamp_pack uStamp (
		.rtcYear   (rtcYear),
		.rtcMonth  (rtcMonth),
		.rtcDay    (rtcDay),
		.rtcHour   (rtcHour),
		.rtcMinute (rtcMinute),
		.rtcSecond (rtcSecond),
		.rec       (rec.stamp)
	);

	// bank contents
	logic [15:0]       diagCode;
	logic [15:0]       timeYm;
	logic [15:0]       timeDh;
	logic [15:0]       timeMs;
	logic [15:0]       category;
	logic [10:0][15:0] common;
	logic [15:0]       next_diagCode;
	logic [15:0]       next_timeYm;
	logic [15:0]       next_timeDh;
	logic [15:0]       next_timeMs;
	logic [15:0]       next_category;
	logic [10:0][15:0] next_common;

	// whole record loads on one edge, so no reader sees a mixed record
	always_comb begin
		next_diagCode = diagCode;
		next_timeYm   = timeYm;
		next_timeDh   = timeDh;
		next_timeMs   = timeMs;
		next_category = category;
		next_common   = common;
		if (rec.valid) begin
			next_diagCode = rec.code;
			next_timeYm   = rec.tsYm;
			next_timeDh   = rec.tsDh;
			next_timeMs   = rec.tsMs;
			next_category = rec.category;
			next_common   = rec.common;
		end
	end

	// record registers; bus writes never reach them
	always_ff @(posedge clock) begin
		if (srst) begin
			diagCode <= diag_bank_pkg::WORD_RESET;
			timeYm   <= diag_bank_pkg::WORD_RESET;
			timeDh   <= diag_bank_pkg::WORD_RESET;
			timeMs   <= diag_bank_pkg::WORD_RESET;
			category <= diag_bank_pkg::WORD_RESET;
			common   <= '0;
		end else begin
			diagCode <= next_diagCode;
			timeYm   <= next_timeYm;
			timeDh   <= next_timeDh;
			timeMs   <= next_timeMs;
			category <= next_category;
			common   <= next_common;
		end
	end

	// bus decode
	logic [4:0] wordIdx;
	logic       wrAccept;
	assign wordIdx  = address[6:2];
	assign wrAccept = write & ~read;

	// interrupt status and mask
	logic [1:0] irqStat;
	logic [1:0] irqMask;
	logic [1:0] next_irqStat;
	logic [1:0] next_irqMask;
	logic [1:0] statSet;
	logic [1:0] statClr;

	// set wins over a write-one clear in the same cycle
	always_comb begin
		statSet = '0;
		statSet[diag_bank_pkg::STAT_CAPTURE]   = rec.valid;
		statSet[diag_bank_pkg::STAT_OVERWRITE] = rec.valid &
			irqStat[diag_bank_pkg::STAT_CAPTURE];
		statClr = '0;
		if (wrAccept && wordIdx == diag_bank_pkg::IDX_IRQ_STAT &&
				byteenable[0]) begin
			statClr = writedata[1:0];
		end
		next_irqStat = (irqStat & ~statClr) | statSet;
		next_irqMask = irqMask;
		if (wrAccept && wordIdx == diag_bank_pkg::IDX_IRQ_MASK &&
				byteenable[0]) begin
			next_irqMask = writedata[1:0];
		end
	end

	// interrupt registers
	always_ff @(posedge clock) begin
		if (srst) begin
			irqStat <= diag_bank_pkg::STAT_RESET;
			irqMask <= diag_bank_pkg::STAT_RESET;
		end else begin
			irqStat <= next_irqStat;
			irqMask <= next_irqMask;
		end
	end

	assign irq = |(irqStat & irqMask);

	// read mux; record words are read-only, writes to them are dropped
	logic [31:0] readMux;
	always_comb begin
		readMux = diag_bank_pkg::UNMAPPED_READ;
		case (wordIdx)
			diag_bank_pkg::IDX_CODE:     readMux = {16'h0000, diagCode};
			diag_bank_pkg::IDX_YM:       readMux = {16'h0000, timeYm};
			diag_bank_pkg::IDX_DH:       readMux = {16'h0000, timeDh};
			diag_bank_pkg::IDX_MS:       readMux = {16'h0000, timeMs};
			diag_bank_pkg::IDX_CAT:      readMux = {16'h0000, category};
			diag_bank_pkg::IDX_IRQ_STAT: readMux = {30'h00000000, irqStat};
			diag_bank_pkg::IDX_IRQ_MASK: readMux = {30'h00000000, irqMask};
			default: begin
				if (wordIdx >= diag_bank_pkg::IDX_COMMON0 &&
						wordIdx <= diag_bank_pkg::IDX_COMMONN) begin
					readMux = {16'h0000,
						common[4'(wordIdx - diag_bank_pkg::IDX_COMMON0)]};
				end
			end
		endcase
	end

	// read sequencer: one wait cycle, then registered data
	diag_bank_pkg::bus_state_e busState;
	diag_bank_pkg::bus_state_e next_busState;
	logic [31:0]               next_readdata;

	always_comb begin
		next_busState = busState;
		next_readdata = readdata;
		case (busState)
			diag_bank_pkg::BUS_IDLE: begin
				if (read) begin
					next_busState = diag_bank_pkg::BUS_RDATA;
					next_readdata = readMux;
				end
			end
			diag_bank_pkg::BUS_RDATA: begin
				next_busState = diag_bank_pkg::BUS_IDLE;
			end
			default: begin
				next_busState = diag_bank_pkg::BUS_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clock) begin
		if (srst) begin
			busState <= diag_bank_pkg::BUS_IDLE;
			readdata <= diag_bank_pkg::UNMAPPED_READ;
		end else begin
			busState <= next_busState;
			readdata <= next_readdata;
		end
	end

	// writes finish at once, reads stall until data is registered
	assign waitrequest = read & (busState != diag_bank_pkg::BUS_RDATA);

	// checks on the captured record and on the read wait
	a_code_capture: assert property (@(posedge clock) disable iff (srst)
		errValid |=> diagCode == $past(errCode))
		else $error("code word missed the reported error");
	a_code_holds: assert property (@(posedge clock) disable iff (srst)
		!errValid |=> $stable(diagCode))
		else $error("code word changed without a new error");
	a_stamp_ym: assert property (@(posedge clock) disable iff (srst)
		errValid |=> timeYm == {$past(rtcYear), $past(rtcMonth)})
		else $error("year month stamp wrong");
	a_stamp_dh: assert property (@(posedge clock) disable iff (srst)
		errValid |=> timeDh == {$past(rtcDay), $past(rtcHour)})
		else $error("day hour stamp wrong");
	a_stamp_ms: assert property (@(posedge clock) disable iff (srst)
		errValid |=> timeMs == {$past(rtcMinute), $past(rtcSecond)})
		else $error("minute second stamp wrong");
	a_category_word: assert property (@(posedge clock) disable iff (srst)
		errValid |=> category == {$past(indivCat), $past(commonCat)})
		else $error("category word wrong");
	a_common_raw: assert property (@(posedge clock) disable iff (srst)
		errValid && commonCat != diag_bank_pkg::CAT_MODULE_POS
		|=> common == $past(rawCommon))
		else $error("common words not taken as reported");
	a_slot_absent: assert property (@(posedge clock) disable iff (srst)
		errValid && commonCat == diag_bank_pkg::CAT_MODULE_POS &&
		!slotMounted |=> common[0] == 16'h00FF)
		else $error("absent slot not shown as FF");
	a_io_unknown: assert property (@(posedge clock) disable iff (srst)
		errValid && commonCat == diag_bank_pkg::CAT_MODULE_POS &&
		(ioUnknown || branchModule) |=> common[1] == 16'hFFFF)
		else $error("unknown io number not FFFF");
	a_io_divided: assert property (@(posedge clock) disable iff (srst)
		errValid && commonCat == diag_bank_pkg::CAT_MODULE_POS &&
		!ioUnknown && !branchModule
		|=> common[1] == {4'h0, $past(ioStart[15:4])})
		else $error("io number not start over sixteen");
	a_ro_write: assert property (@(posedge clock) disable iff (srst)
		write && !errValid |=> $stable(diagCode) && $stable(common))
		else $error("bus write altered a record word");
	a_record_flag: assert property (@(posedge clock) disable iff (srst)
		errValid |=> irqStat[0] && diagCode == $past(errCode) &&
		timeMs == {$past(rtcMinute), $past(rtcSecond)})
		else $error("record and capture flag not updated together");
	a_read_wait: assert property (@(posedge clock) disable iff (srst)
		read && busState == diag_bank_pkg::BUS_IDLE
		|-> waitrequest ##1 !waitrequest)
		else $error("read answer not one cycle late");

	// checks on status, mask, interrupt and read data
	a_overwrite_flag: assert property (@(posedge clock) disable iff (srst)
		errValid && irqStat[0] |=> irqStat[1])
		else $error("second capture left overwrite flag clear");
	a_stat_sticky: assert property (@(posedge clock) disable iff (srst)
		!errValid && !write |=> irqStat == $past(irqStat))
		else $error("status bit changed without event or clear");
	a_stat_clear: assert property (@(posedge clock) disable iff (srst)
		write && !read && address[6:2] == diag_bank_pkg::IDX_IRQ_STAT &&
		byteenable[0] && writedata[0] && !errValid |=> !irqStat[0])
		else $error("write of one left capture flag set");
	a_mask_write: assert property (@(posedge clock) disable iff (srst)
		write && !read && address[6:2] == diag_bank_pkg::IDX_IRQ_MASK &&
		byteenable[0] |=> irqMask == $past(writedata[1:0]))
		else $error("mask write not taken");
	a_irq_level: assert property (@(posedge clock) disable iff (srst)
		errValid && irqMask[0] |=> irq)
		else $error("unmasked capture raised no interrupt");
	a_rdata_holds: assert property (@(posedge clock) disable iff (srst)
		!read && busState == diag_bank_pkg::BUS_IDLE |=> $stable(readdata))
		else $error("read data changed without a read");
endmodule : diagnostic_error_capture_bank
`default_nettype wire

//--- design/diag_bank_pkg.sv
// shared constants and types for the diagnostic error capture bank
package diag_bank_pkg;

	// bank geometry
	localparam int unsigned NUM_COMMON    = 11;

	// word indices, byte address is index times four
	localparam logic [4:0]  IDX_CODE      = 5'h00;
	localparam logic [4:0]  IDX_YM        = 5'h01;
	localparam logic [4:0]  IDX_DH        = 5'h02;
	localparam logic [4:0]  IDX_MS        = 5'h03;
	localparam logic [4:0]  IDX_CAT       = 5'h04;
	localparam logic [4:0]  IDX_COMMON0   = 5'h05;
	localparam logic [4:0]  IDX_COMMONN   = 5'h0F;
	localparam logic [4:0]  IDX_IRQ_STAT  = 5'h10;
	localparam logic [4:0]  IDX_IRQ_MASK  = 5'h11;

	// common information formats and sentinels
	localparam logic [7:0]  CAT_MODULE_POS = 8'h01;
	localparam logic [7:0]  SLOT_NONE      = 8'hFF;
	localparam logic [15:0] IO_NONE        = 16'hFFFF;
	localparam int unsigned IO_DIV_SHIFT   = 4;
	localparam int unsigned WORD_SLOT      = 0;
	localparam int unsigned WORD_IO        = 1;

	// category word layout
	localparam int unsigned CAT_COMMON_LSB = 0;
	localparam int unsigned CAT_INDIV_LSB  = 8;

	// interrupt status bits
	localparam int unsigned STAT_CAPTURE   = 0;
	localparam int unsigned STAT_OVERWRITE = 1;
	localparam int unsigned STAT_WIDTH     = 2;

	// reset values
	localparam logic [15:0] WORD_RESET     = 16'h0000;
	localparam logic [1:0]  STAT_RESET     = 2'h0;
	localparam logic [31:0] UNMAPPED_READ  = 32'h00000000;

	// bus read sequencer
	typedef enum logic [1:0] {
		BUS_IDLE  = 2'b01,
		BUS_RDATA = 2'b10
	} bus_state_e;

	// two BCD bytes into one word, upper first
	function automatic logic [15:0] pack_bcd(input logic [7:0] hi,
		input logic [7:0] lo);
		pack_bcd = {hi, lo};
	endfunction : pack_bcd

endpackage : diag_bank_pkg

//--- design/err_record_if.sv
// interface carrying one formatted error record into the bank
`timescale 1ns/1ps
`default_nettype none
interface err_record_if;
	logic              valid;
	logic [15:0]       code;
	logic [15:0]       category;
	logic [10:0][15:0] common;
	logic [15:0]       tsYm;
	logic [15:0]       tsDh;
	logic [15:0]       tsMs;

	modport fmt   (output valid, output code, output category,
		output common);
	modport stamp (output tsYm, output tsDh, output tsMs);
	modport bank  (input valid, input code, input category, input common,
		input tsYm, input tsDh, input tsMs);
endinterface : err_record_if
`default_nettype wire

//--- design/error_detail_format.sv
// builds code, category and common words for one error report
`timescale 1ns/1ps
`default_nettype none
module error_detail_format (
	input  wire logic              errValid,
	input  wire logic [15:0]       errCode,
	input  wire logic [7:0]        commonCat,
	input  wire logic [7:0]        indivCat,
	input  wire logic              slotMounted,
	input  wire logic [7:0]        slotNo,
	input  wire logic [15:0]       ioStart,
	input  wire logic              ioUnknown,
	input  wire logic              branchModule,
	input  wire logic [10:0][15:0] rawCommon,
	err_record_if.fmt              rec
);
	// code and category pass straight on
	assign rec.valid    = errValid;
	assign rec.code     = errCode;
	assign rec.category = {indivCat, commonCat};

	// module-position format overrides the first two words
	always_comb begin
		rec.common = rawCommon;
		if (commonCat == diag_bank_pkg::CAT_MODULE_POS) begin
			rec.common[diag_bank_pkg::WORD_SLOT] = {8'h00,
				slotMounted ? slotNo : diag_bank_pkg::SLOT_NONE};
			if (ioUnknown || branchModule) begin
				rec.common[diag_bank_pkg::WORD_IO] =
					diag_bank_pkg::IO_NONE;
			end else begin
				rec.common[diag_bank_pkg::WORD_IO] =
					ioStart >> diag_bank_pkg::IO_DIV_SHIFT;
			end
		end
	end
endmodule : error_detail_format
`default_nettype wire

//--- design/time_stamp_pack.sv
// packs the calendar clock into three BCD timestamp words
`timescale 1ns/1ps
`default_nettype none
module time_stamp_pack (
	input  wire logic [7:0] rtcYear,
	input  wire logic [7:0] rtcMonth,
	input  wire logic [7:0] rtcDay,
	input  wire logic [7:0] rtcHour,
	input  wire logic [7:0] rtcMinute,
	input  wire logic [7:0] rtcSecond,
	err_record_if.stamp     rec
);
	// year over month, day over hour, minute over second
	assign rec.tsYm = diag_bank_pkg::pack_bcd(rtcYear, rtcMonth);
	assign rec.tsDh = diag_bank_pkg::pack_bcd(rtcDay, rtcHour);
	assign rec.tsMs = diag_bank_pkg::pack_bcd(rtcMinute, rtcSecond);
endmodule : time_stamp_pack
`default_nettype wire

//--- sim/diagnostic_error_capture_bank_tb_top.sv
// self-checking bench for the diagnostic error capture bank
`timescale 1ns/1ps
`default_nettype none
module diagnostic_error_capture_bank_tb_top;
	logic              clock        = 1'b0;
	logic              srst         = 1'b1;
	logic              errValid     = 1'b0;
	logic [15:0]       errCode      = 16'h0000;
	logic [7:0]        commonCat    = 8'h00;
	logic [7:0]        indivCat     = 8'h00;
	logic              slotMounted  = 1'b0;
	logic [7:0]        slotNo       = 8'h00;
	logic [15:0]       ioStart      = 16'h0000;
	logic              ioUnknown    = 1'b0;
	logic              branchModule = 1'b0;
	logic [10:0][15:0] rawCommon;
	logic [47:0]       rtc          = 48'h000000000000;
	logic [6:0]        address      = 7'h00;
	logic              read         = 1'b0;
	logic              write        = 1'b0;
	logic [31:0]       writedata    = 32'h00000000;
	logic [3:0]        byteenable   = 4'hF;
	logic [31:0]       readdata;
	logic              waitrequest;
	logic              irq;
	logic [31:0]       rd;
	int                failures     = 0;
	int                checks       = 0;

	// free-running system clock
	always #5 clock = ~clock;

	diagnostic_error_capture_bank dut_u (
		.clock(clock), .srst(srst), .errValid(errValid), .errCode(errCode),
		.commonCat(commonCat), .indivCat(indivCat),
		.slotMounted(slotMounted), .slotNo(slotNo), .ioStart(ioStart),
		.ioUnknown(ioUnknown), .branchModule(branchModule),
		.rawCommon(rawCommon), .rtcYear(rtc[47:40]), .rtcMonth(rtc[39:32]),
		.rtcDay(rtc[31:24]), .rtcHour(rtc[23:16]), .rtcMinute(rtc[15:8]),
		.rtcSecond(rtc[7:0]), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq)
	);

	// print the counts and the verdict, then stop
	task complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// compare one bus word
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk

	// compare the interrupt level
	task chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: irq %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	// one avalon access, held until a rising edge samples waitrequest low;
	// a slave that never answers is caught by the watchdog
	task bus(input logic wr, input logic [4:0] idx, input logic [31:0] d);
		@(posedge clock);
		read <= ~wr;
		write <= wr;
		address <= {idx, 2'b00};
		writedata <= d;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	// read one word and compare its low half, upper half zero
	task rd_chk(input logic [4:0] idx, input logic [15:0] exp);
		bus(1'b0, idx, 32'h00000000);
		chk(rd, {16'h0000, exp});
	endtask : rd_chk

	// raise the error strobe with one report and its timestamp
	task fire(input logic [15:0] c, input logic [7:0] cc, input logic [7:0] ic,
		input logic m, input logic [7:0] s, input logic [15:0] io,
		input logic u, input logic b, input logic [47:0] t);
		@(posedge clock);
		errValid <= 1'b1;
		errCode <= c;
		commonCat <= cc;
		indivCat <= ic;
		slotMounted <= m;
		slotNo <= s;
		ioStart <= io;
		ioUnknown <= u;
		branchModule <= b;
		rtc <= t;
	endtask : fire

	// drop the error strobe
	task idle;
		@(posedge clock);
		errValid <= 1'b0;
	endtask : idle

	// read back the whole record
	task check_rec(input logic [15:0] c, input logic [15:0] cat,
		input logic [15:0] c0, input logic [15:0] c1, input logic [47:0] t);
		rd_chk(5'h00, c);
		rd_chk(5'h01, t[47:32]);
		rd_chk(5'h02, t[31:16]);
		rd_chk(5'h03, t[15:0]);
		rd_chk(5'h04, cat);
		rd_chk(5'h05, c0);
		rd_chk(5'h06, c1);
		for (int i = 2; i < 11; i++) begin
			rd_chk(5'(i + 5), rawCommon[i]);
		end
	endtask : check_rec

	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		$display("ERROR %0t: watchdog expired", $time);
		complete_run;
	end

	// test sequence
	initial begin
		for (int i = 0; i < 11; i++) rawCommon[i] = 16'hC000 | 16'(i);
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		// every word clears on reset, unmapped space reads zero
		for (int i = 0; i < 18; i++) begin
			rd_chk(5'(i), 16'h0000);
		end
		rd_chk(5'h1F, 16'h0000);
		// module position report: empty slot, scaled io number
		fire(16'h07D0, 8'h01, 8'h05, 1'b0, 8'h03, 16'h0120, 1'b0, 1'b0,
			48'h951025103548);
		idle;
		check_rec(16'h07D0, 16'h0501, 16'h00FF, 16'h0012,
			48'h951025103548);
		// software writes to record words are dropped
		bus(1'b1, 5'h00, 32'h0000FFFF);
		bus(1'b1, 5'h06, 32'h0000FFFF);
		rd_chk(5'h00, 16'h07D0);
		rd_chk(5'h06, 16'h0012);
		// interrupt only once unmasked, cleared by writing one
		rd_chk(5'h10, 16'h0001);
		chk_bit(irq, 1'b0);
		bus(1'b1, 5'h11, 32'h00000001);
		rd_chk(5'h11, 16'h0001);
		chk_bit(irq, 1'b1);
		bus(1'b1, 5'h10, 32'h00000001);
		rd_chk(5'h10, 16'h0000);
		chk_bit(irq, 1'b0);
		// back to back reports: newest wins whole, branch io reads FFFF
		fire(16'h1000, 8'h01, 8'h00, 1'b1, 8'h02, 16'h0040, 1'b1, 1'b0,
			48'h991231235959);
		fire(16'h2001, 8'h01, 8'h0A, 1'b1, 8'h07, 16'h0050, 1'b0, 1'b1,
			48'h000101000000);
		idle;
		check_rec(16'h2001, 16'h0A01, 16'h0007, 16'hFFFF,
			48'h000101000000);
		rd_chk(5'h10, 16'h0003);
		chk_bit(irq, 1'b1);
		// unknown io number with slot zero
		fire(16'h3002, 8'h01, 8'h00, 1'b1, 8'h00, 16'hFFF0, 1'b1, 1'b0,
			48'h991231235959);
		idle;
		rd_chk(5'h06, 16'hFFFF);
		rd_chk(5'h05, 16'h0000);
		// top start number scales down, mounted slot shows its number
		fire(16'h3003, 8'h01, 8'h00, 1'b1, 8'h10, 16'hFFF0, 1'b0, 1'b0,
			48'h991231235959);
		idle;
		rd_chk(5'h06, 16'h0FFF);
		rd_chk(5'h05, 16'h0010);
		// other format: all common words pass through
		fire(16'h4004, 8'h02, 8'h03, 1'b0, 8'h05, 16'h0100, 1'b1, 1'b1,
			48'h240229120000);
		idle;
		check_rec(16'h4004, 16'h0302, rawCommon[0], rawCommon[1],
			48'h240229120000);
		// overwrite bit alone drives the interrupt through its mask
		bus(1'b1, 5'h10, 32'h00000003);
		bus(1'b1, 5'h11, 32'h00000002);
		rd_chk(5'h10, 16'h0000);
		chk_bit(irq, 1'b0);
		fire(16'h5005, 8'h02, 8'h00, 1'b0, 8'h00, 16'h0000, 1'b0, 1'b0,
			48'h240229120001);
		idle;
		rd_chk(5'h10, 16'h0001);
		chk_bit(irq, 1'b0);
		fire(16'h5006, 8'h02, 8'h00, 1'b0, 8'h00, 16'h0000, 1'b0, 1'b0,
			48'h240229120002);
		idle;
		rd_chk(5'h10, 16'h0003);
		chk_bit(irq, 1'b1);
		rd_chk(5'h00, 16'h5006);
		// a write without the low byte lane leaves the mask alone
		byteenable <= 4'hE;
		bus(1'b1, 5'h11, 32'h00000000);
		byteenable <= 4'hF;
		rd_chk(5'h11, 16'h0002);
		complete_run;
	end
endmodule : diagnostic_error_capture_bank_tb_top
`default_nettype wire
